// File: hw/adc_ctrl_pkg.sv
// Package for the converter select-update and start control block.
// Assumes one 200 MHz clock and a plain register port.
package adc_ctrl_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] OFS_SELECT = 4'h0;
  localparam logic [3:0] OFS_CTRL_A = 4'h1;
  localparam logic [3:0] OFS_CTRL_B = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h3;
  localparam logic [7:0] SELECT_RESET = 8'h00;

  // Select register fields
  localparam int REF_POS = 6;
  localparam int CHAN_POS = 0;

  // Control A fields
  localparam int ON_POS = 7;
  localparam int GO_POS = 6;
  localparam int AUTO_POS = 5;
  localparam int DONE_POS = 4;
  localparam int IE_POS = 3;
  localparam int PS_POS = 0;

  // Control B fields
  localparam int AMP_POS = 7;
  localparam int TSEL_POS = 0;

  // Trigger source codes
  localparam logic [2:0] TRIG_FREE = 3'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam logic [4:0] NORMAL_CYCLES = 5'd13;
  localparam logic [4:0] FIRST_CYCLES = 5'd25;
  localparam logic [4:0] HOLD_FIRST = 5'h0D;
  localparam logic [4:0] HOLD_NORMAL = 5'h03;

  // Applied selection travelling to the analog front end
  typedef struct packed {
    logic [1:0] refSel;
    logic [3:0] chanSel;
  } select_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CONV = 3'b100
  } state_type;

endpackage : adc_ctrl_pkg

// File: hw/adc_select_update_and_start.sv
// Start control and selection buffering of a successive-approximation
// converter. Assumes synchronous inputs on clk and a plain register port.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module adc_select_update_and_start
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arstN,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Events from the system
  input wire logic [7:0] trigSources,
  input wire logic ampTrigger,
  input wire logic ampChannel,
  input wire logic sleepIdleNoise,
  // Analog front end and CPU
  output select_type appliedSel,
  output logic convBusy,
  output logic sampleHold,
  output logic convEnd,
  output logic irqReq
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] select_q;
  logic convOn_q, go_q, auto_q, done_q, ie_q;
  logic [2:0] ps_q;
  logic ampReq_q;
  logic [2:0] tsel_q;
  logic firstPending_q;
  logic [6:0] pre_q;
  logic trigPrev_q;
  logic sleepPrev_q;
  logic ampConv_q;
  logic [4:0] cyc_q;
  logic [4:0] len_q;
  state_type state_q;
  logic [7:0] rd_d;

  // Prescaled converter clock tick
  logic tick;
  logic trigLevel, trigEdge, sleepStart;
  logic lastCycle, finish;
  logic freeRun;
  logic wrSel, wrA, wrB;

  assign wrSel = regWrite && regAddr == OFS_SELECT;
  assign wrA = regWrite && regAddr == OFS_CTRL_A;
  assign wrB = regWrite && regAddr == OFS_CTRL_B;

  function automatic logic prescale_tick(input logic [6:0] cnt,
                                         input logic [2:0] ps);
    logic [6:0] mask;
    mask = 7'h7F >> (3'd7 - ps);
    prescale_tick = ps == 3'd0 ? 1'b1 : (cnt & mask) == mask;
  endfunction

  assign tick = prescale_tick(pre_q, ps_q);
  assign trigLevel = tsel_q == TRIG_FREE ? done_q : trigSources[tsel_q];
  // Free running restarts in the state machine, not on the done edge
  assign trigEdge = auto_q && convOn_q && tsel_q != TRIG_FREE
    && trigLevel && !trigPrev_q;
  // Amplified conversions never chain on their own
  assign freeRun = auto_q && tsel_q == TRIG_FREE && !ampConv_q;
  assign sleepStart = sleepIdleNoise && !sleepPrev_q && !auto_q
    && convOn_q && state_q == ST_IDLE && ie_q;
  assign lastCycle = state_q == ST_CONV && cyc_q == len_q - 5'd1;
  assign finish = lastCycle && tick;

  // ****************************************
  // Selection buffering
  // ****************************************
  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      select_q <= SELECT_RESET;
    end else if (wrSel) begin
      select_q <= regWrData;
    end
  end

  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      appliedSel <= '0;
    end else if (state_q != ST_CONV || lastCycle) begin
      appliedSel.refSel <= select_q[REF_POS +: 2];
      appliedSel.chanSel <= select_q[CHAN_POS +: 4];
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      convOn_q <= 1'b0;
      auto_q <= 1'b0;
      ie_q <= 1'b0;
      ps_q <= 3'h0;
      tsel_q <= 3'h0;
    end else begin
      if (wrA) begin
        convOn_q <= regWrData[ON_POS];
        auto_q <= regWrData[AUTO_POS];
        ie_q <= regWrData[IE_POS];
        ps_q <= regWrData[PS_POS +: 3];
      end
      if (wrB) begin
        tsel_q <= regWrData[TSEL_POS +: 3];
      end
    end
  end

  // Amplified start request, consumed by the amplifier event
  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      ampReq_q <= 1'b0;
    end else if (ampReq_q && ampTrigger && convOn_q) begin
      ampReq_q <= 1'b0;
    end else if (wrB) begin
      ampReq_q <= regWrData[AMP_POS];
    end
  end

  // Done flag: set wins over a write-one clear
  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      done_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
    end else if (wrA && regWrData[DONE_POS]) begin
      done_q <= 1'b0;
    end
  end

  // ****************************************
  // Start bit and state machine
  // ****************************************
  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      go_q <= 1'b0;
    end else if (!convOn_q) begin
      go_q <= 1'b0;
    end else if (wrA && regWrData[GO_POS]) begin
      go_q <= 1'b1;
    end else if (ampReq_q && ampTrigger) begin
      go_q <= 1'b1;
    end else if (sleepStart) begin
      go_q <= 1'b1;
    // Free running keeps the start bit high between conversions
    end else if (finish && !freeRun) begin
      go_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      trigPrev_q <= 1'b0;
      sleepPrev_q <= 1'b0;
    end else begin
      trigPrev_q <= trigLevel;
      sleepPrev_q <= sleepIdleNoise;
    end
  end

  // Prescaler runs while enabled, reset by a trigger edge while idle
  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      pre_q <= 7'h00;
    end else if (!convOn_q || (trigEdge && state_q == ST_IDLE)) begin
      pre_q <= 7'h00;
    end else begin
      pre_q <= pre_q + 7'd1;
    end
  end

  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      firstPending_q <= 1'b1;
    end else if (!convOn_q) begin
      firstPending_q <= 1'b1;
    end else if (state_q == ST_WAIT && tick) begin
      firstPending_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      state_q <= ST_IDLE;
      cyc_q <= 5'd0;
      len_q <= NORMAL_CYCLES;
      ampConv_q <= 1'b0;
    end else if (!convOn_q) begin
      state_q <= ST_IDLE;
      cyc_q <= 5'd0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (trigEdge || go_q || (ampReq_q && ampTrigger)) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (tick) begin
            state_q <= ST_CONV;
            cyc_q <= 5'd0;
            len_q <= firstPending_q ? FIRST_CYCLES : NORMAL_CYCLES;
            ampConv_q <= ampChannel;
          end
        end
        ST_CONV: begin
          if (tick) begin
            if (finish) begin
              cyc_q <= 5'd0;
              if (freeRun) begin
                state_q <= ST_CONV;
                len_q <= NORMAL_CYCLES;
                ampConv_q <= ampChannel;
              end else begin
                state_q <= ST_IDLE;
              end
            end else begin
              cyc_q <= cyc_q + 5'd1;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      convBusy <= 1'b0;
      sampleHold <= 1'b0;
      convEnd <= 1'b0;
      irqReq <= 1'b0;
    end else begin
      convBusy <= state_q == ST_CONV;
      // Hold point keyed to the running length; the first-pending mark
      // is already gone once the conversion runs
      sampleHold <= state_q == ST_CONV && tick
        && cyc_q == (len_q == FIRST_CYCLES ? HOLD_FIRST : HOLD_NORMAL);
      convEnd <= finish;
      irqReq <= (done_q || finish) && ie_q;
    end
  end

  // Read data: select register returns the temporary copy
  always_comb begin
    rd_d = 8'h00;
    if (regAddr == OFS_SELECT) begin
      rd_d = select_q;
    end else if (regAddr == OFS_CTRL_A) begin
      rd_d = {convOn_q, go_q || state_q != ST_IDLE, auto_q, done_q,
              ie_q, ps_q};
    end else if (regAddr == OFS_CTRL_B) begin
      rd_d = {ampReq_q, 4'h0, tsel_q};
    end else if (regAddr == OFS_STATUS) begin
      rd_d = {5'h00, state_q};
    end
  end

  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= regRead ? rd_d : 8'h00;
    end
  end

endmodule // adc_select_update_and_start
`default_nettype wire

// File: tb/adc_select_update_and_start_assertions.sv
// Checker for the select-update and start block.
// Bound to the top module; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module adc_select_update_and_start_assertions
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arstN,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // Front end
  input wire select_type appliedSel,
  input wire logic convBusy,
  input wire logic convEnd,
  input wire logic irqReq
);
  // ****************************************
  // Checks
  // ****************************************
  logic [7:0] tempQ;
  default clocking @(posedge clk); endclocking
  default disable iff (!arstN);
  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) tempQ <= SELECT_RESET;
    else if (regWrite && regAddr == OFS_SELECT) tempQ <= regWrData;
  end
  sequence busyRun;
    $rose(convBusy) ##1 convBusy;
  endsequence
  sequence selRead;
    regRead && regAddr == OFS_SELECT;
  endsequence
  sel_frozen_a: assert property (busyRun |=> $stable(appliedSel))
    else $error("applied selection moved");
  sel_read_a: assert property (selRead |=> regRdData == tempQ)
    else $error("select read wrong");
  idle_follow_a: assert property (!convBusy && $past(!convBusy)
    && !$past(regWrite) |-> appliedSel == {tempQ[7:6], tempQ[3:0]})
    else $error("idle selection not copied");
  end_copy_a: assert property (convEnd && !$past(regWrite)
    |-> appliedSel == {tempQ[7:6], tempQ[3:0]})
    else $error("selection not copied at end");
  end_pulse_a: assert property (convEnd |=> !convEnd)
    else $error("end pulse too long");
  end_busy_a: assert property (convEnd |-> $past(convBusy))
    else $error("end without busy");
  busy_hold_a: assert property ($rose(convBusy) |-> convBusy[*8])
    else $error("conversion too short");
  irq_rise_a: assert property ($rose(irqReq) |-> $past(regWrite, 2)
    || $past(convBusy) || $past(convBusy, 2))
    else $error("interrupt without cause");
endmodule // adc_select_update_and_start_assertions
`default_nettype wire

// File: tb/adc_select_update_and_start_test.sv
// Bench for the select-update and start block.
// Uses the front end model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module adc_select_update_and_start_test;
  import adc_ctrl_pkg::*;
  logic clk = 0, arstN = 0, regWrite = 0, regRead = 0;
  logic ampChannel = 0, sleepIdleNoise = 0, fireTrig = 0, armAmp = 0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00, regRdData, trigSources, rdv;
  logic ampTrigger, convBusy, sampleHold, convEnd, irqReq;
  select_type appliedSel;
  int errors = 0, samples_checked = 0, n1, n2, ends, sh;
  always #2.5 clk = ~clk;
  adc_select_update_and_start u_adc_select_update_and_start (.clk(clk),
    .arstN(arstN), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .trigSources(trigSources), .ampTrigger(ampTrigger),
    .ampChannel(ampChannel), .sleepIdleNoise(sleepIdleNoise),
    .appliedSel(appliedSel), .convBusy(convBusy),
    .sampleHold(sampleHold), .convEnd(convEnd), .irqReq(irqReq));
  front_end_model u_front_end_model (.clk(clk), .arstN(arstN),
    .fireTrig(fireTrig), .armAmp(armAmp), .trigSources(trigSources),
    .ampTrigger(ampTrigger));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk8(string s, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(logic [3:0] a);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 rdv = regRdData;
    @(posedge clk);
  endtask
  task automatic waitEnd(output int n);
    n = 0;
    sh = 0;
    while (convEnd !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1 n++;
      if (sampleHold === 1'b1) sh = n;
    end
    chk8("end seen", 8'h01, {7'h0, convEnd});
  endtask
  task automatic regs();
    rd(OFS_SELECT);
    chk8("select reset", SELECT_RESET, rdv);
    wr(OFS_SELECT, 8'hF5);
    rd(OFS_SELECT);
    chk8("select", 8'hF5, rdv);
    chk8("idle applied", 8'h35, {2'b0, appliedSel});
    rd(4'hA);
    chk8("unmapped", 8'h00, rdv);
  endtask
  task automatic single();
    wr(OFS_CTRL_A, 8'h80);
    wr(OFS_SELECT, 8'h43);
    wr(OFS_CTRL_A, 8'hC0);
    waitEnd(n1);
    chk8("hold first", 8'(HOLD_FIRST + 5'h02), 8'(sh));
    wr(OFS_CTRL_A, 8'hD0);
    waitEnd(n2);
    chk8("hold normal", 8'(HOLD_NORMAL + 5'h02), 8'(sh));
    chk8("length diff", 8'd12, 8'(n1 - n2));
    wr(OFS_CTRL_A, 8'hD0);
    wr(OFS_SELECT, 8'h8A);
    rd(OFS_CTRL_A);
    chk8("go busy", 8'h01, {7'h0, rdv[GO_POS]});
    chk8("locked", 8'h13, {2'b0, appliedSel});
    rd(OFS_SELECT);
    chk8("temp", 8'h8A, rdv);
    waitEnd(n1);
    chk8("resumed", 8'h2A, {2'b0, appliedSel});
    rd(OFS_CTRL_A);
    chk8("go done", 8'h01, {5'h0, rdv[GO_POS:DONE_POS]});
    wr(OFS_CTRL_A, 8'hD0);
    waitEnd(n2);
  endtask
  task automatic autoTrig();
    wr(OFS_CTRL_B, 8'h01);
    wr(OFS_CTRL_A, 8'hB0);
    ends = 0;
    for (int i = 0; i < 150; i++) begin
      fireTrig <= (i == 0 || i == 8);
      regWrite <= (i == 5);
      regAddr <= OFS_SELECT;
      regWrData <= 8'h4C;
      @(posedge clk);
      #1 ends += convEnd;
      if (i == 10) chk8("auto locked", 8'h2A, {2'b0, appliedSel});
    end
    chk8("trigger ends", 8'h01, 8'(ends));
    chk8("auto applied", 8'h1C, {2'b0, appliedSel});
    wr(OFS_CTRL_A, 8'h90);
  endtask
  task automatic freeRunning();
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_CTRL_A, 8'hE0);
    waitEnd(n1);
    wr(OFS_SELECT, 8'h47);
    chk8("running old", 8'h1C, {2'b0, appliedSel});
    waitEnd(n1);
    chk8("next new", 8'h17, {2'b0, appliedSel});
    wr(OFS_CTRL_A, 8'h90);
    waitEnd(n2);
  endtask
  task automatic amp();
    ampChannel <= 1'b1;
    wr(OFS_CTRL_A, 8'hB0);
    wr(OFS_CTRL_B, 8'h80);
    armAmp <= 1'b1;
    @(posedge clk);
    armAmp <= 1'b0;
    repeat (10) @(posedge clk);
    chk8("waits event", 8'h00, {7'h0, convBusy});
    waitEnd(n1);
    repeat (4) @(posedge clk);
    rd(OFS_CTRL_A);
    chk8("amp go", 8'h00, {7'h0, rdv[GO_POS]});
    chk8("amp stopped", 8'h00, {7'h0, convBusy});
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_CTRL_A, 8'h90);
    ampChannel <= 1'b0;
  endtask
  task automatic sleep();
    wr(OFS_CTRL_A, 8'h98);
    sleepIdleNoise <= 1'b1;
    repeat (3) @(posedge clk);
    sleepIdleNoise <= 1'b0;
    waitEnd(n1);
    repeat (2) @(posedge clk);
    chk8("irq", 8'h01, {7'h0, irqReq});
    wr(OFS_CTRL_A, 8'h10);
    wr(OFS_CTRL_A, 8'h80);
    wr(OFS_CTRL_A, 8'hC0);
    waitEnd(n1);
    chk8("extended", 8'(FIRST_CYCLES + 5'h01), 8'(n1));
  endtask
  task automatic results();
    $display("Checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    arstN <= 1'b1;
    @(posedge clk);
    regs();
    single();
    autoTrig();
    freeRunning();
    amp();
    sleep();
    results();
  end
  initial begin
    #100000;
    errors++;
    results();
  end
endmodule // adc_select_update_and_start_test
bind adc_select_update_and_start adc_select_update_and_start_assertions
  u_chk (.clk(clk), .arstN(arstN), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .appliedSel(appliedSel), .convBusy(convBusy),
  .convEnd(convEnd), .irqReq(irqReq));
`default_nettype wire

// File: tb/front_end_model.sv
// Model of the trigger sources and amplifier events.
// Driven by the bench through two command pulses.
`timescale 1ns/10ps
`default_nettype none
module front_end_model (
  // Clock and reset
  input wire logic clk,
  input wire logic arstN,
  // Commands
  input wire logic fireTrig,
  input wire logic armAmp,
  // Events
  output logic [7:0] trigSources,
  output logic ampTrigger
);
  logic [4:0] trigCnt;
  logic [4:0] ampCnt;
  assign trigSources = {6'h00, trigCnt != 5'h00, 1'b0};
  assign ampTrigger = ampCnt == 5'h01;
  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      trigCnt <= 5'h00;
      ampCnt <= 5'h00;
    end else begin
      trigCnt <= fireTrig ? 5'h04 : trigCnt - {4'h0, trigCnt != 5'h00};
      ampCnt <= armAmp ? 5'h14 : ampCnt - {4'h0, ampCnt != 5'h00};
    end
  end
endmodule // front_end_model
`default_nettype wire
